// *** src/sys_clock_pkg.sv ***
// constants, types and register map of the system clock prescaler
package sys_clock_pkg;

  localparam logic [7:0] OFS_PRESCALE   = 8'h61;
  localparam logic [7:0] OFS_TRIM       = 8'h66;

  localparam int         PCE_BIT        = 7;
  localparam int         SEL_W          = 4;
  localparam int         RANGE_BIT      = 7;
  localparam int         TUNE_W         = 7;

  localparam logic [7:0] PCE_UNLOCK     = 8'h80;
  localparam logic [3:0] SEL_MAX        = 4'h8;
  localparam logic [3:0] SEL_RST_PLAIN  = 4'h0;
  localparam logic [3:0] SEL_RST_DIV8   = 4'h3;
  localparam logic [2:0] PCE_WINDOW     = 3'h4;
  localparam logic [7:0] RD_IDLE        = 8'h00;
  localparam int         CNT_W_MIN      = 8;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_RUN,
    ST_SWITCH
  } presc_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic io;
    logic cpu;
    logic flash;
  } clk_en_s;

endpackage : sys_clock_pkg

// *** src/system_clock_prescaler.sv ***
// system clock prescaler, oscillator trim register and clock output buffer
`timescale 1ns/1ps
`default_nettype none

module system_clock_prescaler
  import sys_clock_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic       clk,                // undivided source clock
  input  wire logic       rst_n,              // async reset, active low
  input  wire logic       ce,                 // clock enable, freezes state
  input  wire reg_req_s   regReq,             // register port request
  output logic [7:0]      regRdata,           // read data, cycle after read
  input  wire logic       clockOutputFuse,    // fuse: clock on output pin
  input  wire logic       divideByEightFuse,  // fuse: reset divide by 8
  input  wire logic [7:0] factoryTrim,        // factory trim value
  output clk_en_s         clkEn,              // divided clock enables
  output logic            sysClkLevel,        // divided clock level
  output logic [3:0]      activeSelect,       // division code in effect
  output logic            oscRangeHigh,       // trim range select
  output logic [6:0]      oscTune,            // trim value bits
  input  wire logic       gpioOut,            // ordinary pin drive value
  input  wire logic       gpioOe_n,           // ordinary pin enable, low drives
  output logic            gpioIn,             // ordinary pin level
  input  wire logic       sysClkPinIn,        // pin level in
  output logic            sysClkPinOut,       // pin drive value
  output logic            sysClkPinOe_n       // pin enable, low drives
);

  generate
    if (CNT_W < CNT_W_MIN) begin : g_chk
      $error("CNT_W too narrow for division by 256");
    end
  endgenerate

  localparam int SYNC_W = 11;

  // two-stage synchronisers for fuses, trim row and the pin
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncA_ff;
  logic [SYNC_W-1:0] syncB_ff;

  assign syncIn = {sysClkPinIn, clockOutputFuse, divideByEightFuse, factoryTrim};

  // no reset: fuse levels must be valid while reset is held
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (ce) begin
          syncA_ff[gi] <= syncIn[gi];
          syncB_ff[gi] <= syncA_ff[gi];
        end
      end
    end
  endgenerate

  logic       pinInS;
  logic       fuseOut;
  logic       fuseDiv8;
  logic [7:0] trimFuse;

  assign pinInS   = syncB_ff[10];
  assign fuseOut  = syncB_ff[9];
  assign fuseDiv8 = syncB_ff[8];
  assign trimFuse = syncB_ff[7:0];

  // register port decode
  logic wrPresc;
  logic wrTrim;
  logic unlockWr;
  logic selWr;
  logic selOk;

  presc_state_e state_ff;
  presc_state_e nxt_state;

  logic             pce_ff;
  logic [2:0]       winCnt_ff;
  logic [3:0]       selReg_ff;
  logic [3:0]       newSel_ff;
  logic [3:0]       effSel_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             level_ff;
  logic [7:0]       trim_ff;
  logic [7:0]       rdata_ff;
  logic [CNT_W:0]   period;
  logic             tick;

  assign wrPresc  = regReq.wr && (regReq.addr == OFS_PRESCALE);
  assign wrTrim   = regReq.wr && (regReq.addr == OFS_TRIM);
  assign unlockWr = wrPresc && (regReq.wdata == PCE_UNLOCK);
  assign selWr    = wrPresc && pce_ff && !regReq.wdata[PCE_BIT];
  assign selOk    = regReq.wdata[SEL_W-1:0] <= SEL_MAX;

  // change-enable and its four-cycle window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pce_ff    <= 1'b0;
      winCnt_ff <= 3'h0;
    end else if (ce) begin
      if (selWr) begin
        pce_ff    <= 1'b0;
        winCnt_ff <= 3'h0;
      end else if (pce_ff) begin
        winCnt_ff <= winCnt_ff - 3'h1;
        if (winCnt_ff == 3'h1) begin
          pce_ff <= 1'b0;
        end
      end else if (unlockWr) begin
        pce_ff    <= 1'b1;
        winCnt_ff <= PCE_WINDOW;
      end
    end
  end

  // state of the prescale switch
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_LOAD: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (selWr && selOk) begin
          nxt_state = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        if (tick && !(selWr && selOk)) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_LOAD;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // visible, pending and effective selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selReg_ff <= SEL_RST_PLAIN;
      newSel_ff <= SEL_RST_PLAIN;
      effSel_ff <= SEL_RST_PLAIN;
    end else if (ce) begin
      if (state_ff == ST_LOAD) begin
        selReg_ff <= fuseDiv8 ? SEL_RST_DIV8 : SEL_RST_PLAIN;
        newSel_ff <= fuseDiv8 ? SEL_RST_DIV8 : SEL_RST_PLAIN;
        effSel_ff <= fuseDiv8 ? SEL_RST_DIV8 : SEL_RST_PLAIN;
      end else begin
        if (selWr && selOk) begin
          selReg_ff <= regReq.wdata[SEL_W-1:0];
          newSel_ff <= regReq.wdata[SEL_W-1:0];
        end
        // switch only on an old-period boundary: no short period
        if (state_ff == ST_SWITCH && tick) begin
          effSel_ff <= newSel_ff;
        end
      end
    end
  end

  // divider on the source clock, never readable
  assign period  = (CNT_W+1)'(1) << effSel_ff;
  assign tick    = (cnt_ff == CNT_W'(period - (CNT_W+1)'(1)));
  assign nxt_cnt = tick ? '0 : cnt_ff + CNT_W'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // high for the first half of each divided period; toggles every source cycle when undivided
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
    end else if (ce) begin
      if (effSel_ff == SEL_RST_PLAIN) begin
        level_ff <= ~level_ff;
      end else begin
        level_ff <= (nxt_cnt < CNT_W'(period >> 1));
      end
    end
  end

  // the same enable feeds every clock domain
  assign clkEn        = '{io: tick, cpu: tick, flash: tick};
  assign sysClkLevel  = level_ff;
  assign activeSelect = effSel_ff;

  // oscillator trim register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_ff <= 8'h00;
    end else if (ce) begin
      if (state_ff == ST_LOAD) begin
        trim_ff <= trimFuse;
      end else if (wrTrim) begin
        trim_ff <= regReq.wdata;
      end
    end
  end

  assign oscRangeHigh = trim_ff[RANGE_BIT];
  assign oscTune      = trim_ff[TUNE_W-1:0];

  // read data, valid only in the cycle after the read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= RD_IDLE;
    end else if (ce) begin
      rdata_ff <= RD_IDLE;
      if (regReq.rd && regReq.addr == OFS_PRESCALE) begin
        rdata_ff <= {pce_ff, 3'h0, selReg_ff};
      end else if (regReq.rd && regReq.addr == OFS_TRIM) begin
        rdata_ff <= trim_ff;
      end
    end
  end

  assign regRdata = rdata_ff;

  // clock output buffer; during reset the raw source clock is passed
  always_comb begin
    sysClkPinOut  = gpioOut;
    sysClkPinOe_n = gpioOe_n;
    if (fuseOut) begin
      sysClkPinOe_n = 1'b0;
      if (!rst_n || state_ff == ST_LOAD || effSel_ff == SEL_RST_PLAIN) begin
        sysClkPinOut = clk;
      end else begin
        sysClkPinOut = level_ff;
      end
    end
  end

  assign gpioIn = pinInS;

  // helper: cycles since the previous divided clock edge
  logic [CNT_W:0] gap_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= '0;
    end else if (ce) begin
      gap_ff <= tick ? '0 : gap_ff + (CNT_W+1)'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pce_set_only: assert property (
    (ce && wrPresc && regReq.wdata != PCE_UNLOCK && !pce_ff) |=> !pce_ff
  ) else $error("change-enable set by a non-unlock write");

  a_pce_timeout: assert property (
    (ce && $rose(pce_ff)) |-> ##[1:4] !pce_ff
  ) else $error("change-enable outlived its window");

  a_pce_no_restart: assert property (
    (ce && pce_ff && winCnt_ff > 3'h1 && unlockWr) |=>
      (pce_ff && winCnt_ff == $past(winCnt_ff) - 3'h1)
  ) else $error("unlock rewrite restarted or cleared window");

  a_reserved_keep: assert property (
    (ce && selWr && !selOk && state_ff != ST_LOAD) |=> $stable(newSel_ff)
  ) else $error("reserved code changed the division");

  a_period_exact: assert property (
    (ce && tick && state_ff != ST_LOAD) |-> gap_ff == period - (CNT_W+1)'(1)
  ) else $error("divided period differs from active factor");

  a_switch_edge: assert property (
    (ce && state_ff == ST_SWITCH && tick && !selWr) |=>
      (state_ff == ST_RUN && effSel_ff == $past(newSel_ff) && cnt_ff == '0)
  ) else $error("new division not applied at old boundary");

  a_fuse_load: assert property (
    (ce && state_ff == ST_LOAD) |=>
      selReg_ff == ($past(fuseDiv8) ? SEL_RST_DIV8 : SEL_RST_PLAIN)
  ) else $error("reset selection does not follow fuse");

  a_trim_write: assert property (
    (ce && wrTrim && state_ff != ST_LOAD) |=> trim_ff == $past(regReq.wdata)
  ) else $error("trim register missed a write");

  a_pin_divided: assert property (
    (ce && fuseOut && tick && effSel_ff != SEL_RST_PLAIN
      && state_ff == ST_RUN) |=> sysClkPinOut ##1 (sysClkPinOut || tick)
  ) else $error("pin does not carry divided clock");

  a_pin_driven: assert property (
    fuseOut |-> !sysClkPinOe_n
  ) else $error("clock output pin not driven");

  a_read_prescale: assert property (
    (ce && regReq.rd && regReq.addr == OFS_PRESCALE) |=>
      regRdata == {$past(pce_ff), 3'h0, $past(selReg_ff)}
  ) else $error("prescale register read is wrong");

  a_pce_unlock_set: assert property (
    (ce && unlockWr && !pce_ff) |=> (pce_ff && winCnt_ff == PCE_WINDOW)
  ) else $error("unlock write did not open the window");

  a_pce_sel_clear: assert property (
    (ce && selWr) |=> !pce_ff
  ) else $error("selection write left change-enable set");

  a_sel_accept: assert property (
    (ce && selWr && selOk && state_ff != ST_LOAD) |=>
      selReg_ff == $past(regReq.wdata[SEL_W-1:0])
  ) else $error("selection write not taken");

  a_reserved_ignored: assert property (
    (ce && selWr && !selOk) |=> $stable(selReg_ff)
  ) else $error("reserved code changed the readback");

  a_trim_load: assert property (
    (ce && state_ff == ST_LOAD) |=> trim_ff == $past(trimFuse)
  ) else $error("factory trim not loaded after reset");

  a_div_boundary: assert property (
    (ce && state_ff != ST_LOAD && !(state_ff == ST_SWITCH && tick)) |=>
      $stable(effSel_ff)
  ) else $error("division changed off a period boundary");

  a_level_first_half: assert property (
    (ce && tick && effSel_ff != SEL_RST_PLAIN && state_ff == ST_RUN) |=>
      sysClkLevel
  ) else $error("divided clock not high after its edge");

endmodule : system_clock_prescaler

`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking testbench for the system clock prescaler
`timescale 1ns/1ps
`default_nettype none

module testbench
  import sys_clock_pkg::*;
;
  logic       clk;
  logic       rst_n;
  reg_req_s   regReq;
  logic [7:0] regRdata;
  logic       clockOutputFuse;
  logic       divideByEightFuse;
  logic [7:0] factoryTrim;
  clk_en_s    clkEn;
  logic       sysClkLevel;
  logic [3:0] activeSelect;
  logic       oscRangeHigh;
  logic [6:0] oscTune;
  logic       gpioOut;
  logic       gpioOe_n;
  logic       gpioIn;
  logic       sysClkPinOut;
  logic       sysClkPinOe_n;
  wire        pinLevel = sysClkPinOe_n ? 1'b1 : sysClkPinOut;  // pull-up when released
  int         nErrors;
  int         checks;
  int         ga, gb, gc, oldP, newP;

  system_clock_prescaler #(.CNT_W(8)) i_system_clock_prescaler (
    .clk               (clk),
    .rst_n             (rst_n),
    .ce                (1'b1),
    .regReq            (regReq),
    .regRdata          (regRdata),
    .clockOutputFuse   (clockOutputFuse),
    .divideByEightFuse (divideByEightFuse),
    .factoryTrim       (factoryTrim),
    .clkEn             (clkEn),
    .sysClkLevel       (sysClkLevel),
    .activeSelect      (activeSelect),
    .oscRangeHigh      (oscRangeHigh),
    .oscTune           (oscTune),
    .gpioOut           (gpioOut),
    .gpioOe_n          (gpioOe_n),
    .gpioIn            (gpioIn),
    .sysClkPinIn       (pinLevel),
    .sysClkPinOut      (sysClkPinOut),
    .sysClkPinOe_n     (sysClkPinOe_n)
  );

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // request is set at an edge and taken at the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask : wr

  task automatic idle;
    @(posedge clk);
    regReq <= '0;
  endtask : idle

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    @(negedge clk);
    chk({24'h0, regRdata}, {24'h0, exp});
  endtask : rd

  // cycles until the next divided clock tick, sampled mid-cycle
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (clkEn.io !== 1'b1 && n < 600);
    if (n >= 600) begin
      nErrors++;
      $display("Error at %0t: got %0h expected %0h", $time, n, 0);
      end_sim;
    end
    chk({29'h0, clkEn}, 32'h7);
  endtask : gap

  task automatic per(input int exp);
    int n;
    gap(n);
    gap(n);
    chk(n, exp);
  endtask : per

  initial begin
    #200000;
    nErrors++;
    $display("Error at %0t: got %0h expected %0h", $time, 0, 1);
    end_sim;
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    regReq = '0;
    clockOutputFuse = 1'b1;
    divideByEightFuse = 1'b1;
    factoryTrim = 8'hA5;
    gpioOut = 1'b0;
    gpioOe_n = 1'b1;
    nErrors = 0;
    checks = 0;
    repeat (3) @(negedge clk);
    chk({31'h0, sysClkPinOe_n}, 32'h0);
    @(posedge clk);
    #1;
    chk({31'h0, sysClkPinOut}, 32'h1);
    @(negedge clk);
    #1;
    chk({31'h0, sysClkPinOut}, 32'h0);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(OFS_PRESCALE, 8'h03);
    rd(OFS_TRIM, 8'hA5);
    chk({24'h0, oscRangeHigh, oscTune}, 32'hA5);
    per(8);
    @(negedge clk);
    chk({31'h0, sysClkPinOut}, 32'h1);
    repeat (4) @(negedge clk);
    chk({31'h0, sysClkPinOut}, 32'h0);
    wr(OFS_PRESCALE, 8'h81);
    wr(OFS_PRESCALE, 8'h05);
    idle;
    rd(OFS_PRESCALE, 8'h03);
    wr(OFS_PRESCALE, PCE_UNLOCK);
    idle;
    rd(OFS_PRESCALE, 8'h83);
    repeat (4) @(posedge clk);
    wr(OFS_PRESCALE, 8'h05);
    idle;
    rd(OFS_PRESCALE, 8'h03);
    wr(OFS_PRESCALE, PCE_UNLOCK);
    idle;
    wr(OFS_PRESCALE, PCE_UNLOCK);
    idle;
    idle;
    wr(OFS_PRESCALE, 8'h05);
    idle;
    rd(OFS_PRESCALE, 8'h03);
    oldP = 8;
    for (int c = 0; c <= 8; c++) begin
      newP = 1 << c;
      wr(OFS_PRESCALE, PCE_UNLOCK);
      wr(OFS_PRESCALE, 8'(c));
      idle;
      gap(ga);
      gap(gb);
      gap(gc);
      chk(gc, newP);
      chk(32'(gb == oldP || gb == newP), 32'h1);
      chk(32'(ga + gb <= oldP + 2 * newP), 32'h1);
      rd(OFS_PRESCALE, 8'(c));
      chk({28'h0, activeSelect}, c);
      oldP = newP;
    end
    chk({31'h0, sysClkPinOut}, {31'h0, sysClkLevel});
    wr(OFS_PRESCALE, PCE_UNLOCK);
    wr(OFS_PRESCALE, 8'h09);
    idle;
    rd(OFS_PRESCALE, 8'h08);
    per(256);
    wr(OFS_TRIM, 8'h7F);
    idle;
    rd(OFS_TRIM, 8'h7F);
    chk({24'h0, oscRangeHigh, oscTune}, 32'h7F);
    wr(OFS_TRIM, 8'h80);
    idle;
    @(negedge clk);
    chk({24'h0, oscRangeHigh, oscTune}, 32'h80);
    rd(8'h62, 8'h00);
    @(posedge clk);
    clockOutputFuse <= 1'b0;
    gpioOut <= 1'b1;
    gpioOe_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk({30'h0, sysClkPinOe_n, sysClkPinOut}, 32'h1);
    chk({31'h0, gpioIn}, 32'h1);
    @(posedge clk);
    gpioOut <= 1'b0;
    repeat (4) @(negedge clk);
    chk({30'h0, sysClkPinOe_n, sysClkPinOut}, 32'h0);
    chk({31'h0, gpioIn}, 32'h0);
    @(posedge clk);
    gpioOe_n <= 1'b1;
    repeat (4) @(negedge clk);
    chk({31'h0, sysClkPinOe_n}, 32'h1);
    chk({31'h0, gpioIn}, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    divideByEightFuse <= 1'b0;
    factoryTrim <= 8'h3C;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(OFS_PRESCALE, 8'h00);
    rd(OFS_TRIM, 8'h3C);
    per(1);
    end_sim;
  end

endmodule : testbench

`default_nettype wire
